// ### hw/lpi_defines.svh
// Offsets, fields, reset values and timing counts of the sensor control block.
// Assumes a 10 MHz system clock; included by the design only, not by the package.
`ifndef LPI_DEFINES_SVH
`define LPI_DEFINES_SVH

`define LPI_CLK_HZ          10000000
`define LPI_AMB_PERIOD_MS   100
`define LPI_AMB_PERIOD_CYC  (`LPI_AMB_PERIOD_MS * (`LPI_CLK_HZ / 1000))
`define LPI_LED_PULSE_US    100
`define LPI_LED_PULSE_CYC   (`LPI_LED_PULSE_US * (`LPI_CLK_HZ / 1000000))
`define LPI_SLEEP_MAX_MS    800
`define LPI_SLEEP_STEPS     8
`define LPI_SLEEP_UNIT_CYC  ((`LPI_SLEEP_MAX_MS / `LPI_SLEEP_STEPS) * (`LPI_CLK_HZ / 1000))

`define LPI_AMB_MAX         16'h0fff
`define LPI_PROX_MAX        16'h00ff

`define LPI_OFS_CONFIG      8'h00
`define LPI_OFS_INTCFG      8'h04
`define LPI_OFS_AMB_LO      8'h08
`define LPI_OFS_AMB_HI      8'h0c
`define LPI_OFS_PROX_THR    8'h10
`define LPI_OFS_AMB_DATA    8'h14
`define LPI_OFS_PROX_DATA   8'h18
`define LPI_OFS_IRQ_STAT    8'h1c
`define LPI_OFS_IRQ_MASK    8'h20
`define LPI_OFS_INFO        8'h24

`define LPI_CFG_PROX_EN     0
`define LPI_CFG_AMB_EN      1
`define LPI_CFG_RANGE       2
`define LPI_CFG_LED_HIGH    3
`define LPI_CFG_SLEEP_LSB   4
`define LPI_ICF_AMB_P_LSB   0
`define LPI_ICF_PROX_P_LSB  2
`define LPI_ICF_COMBINE     4

`define LPI_RST_CONFIG      7'h00
`define LPI_RST_INTCFG      5'h00
`define LPI_RST_AMB_LO      12'h000
`define LPI_RST_AMB_HI      12'hfff
`define LPI_RST_PROX_THR    8'hff
`define LPI_RST_IRQ_MASK    4'h3

`endif

// ### hw/lpi_pkg.sv
// Types shared by the sensor control block.
// Assumes lpi_defines.svh sits in the include path.
package lpi_pkg;
	typedef enum logic [1:0] {PX_IDLE, PX_LED, PX_SLEEP} lpi_prox_e;
	typedef logic [11:0] lpi_amb_t;
	typedef logic [7:0]  lpi_prox_t;
	typedef logic [4:0]  lpi_cnt_t;
endpackage

// ### hw/lpi_sensor_ctrl.sv
// Control, timing and interrupt logic of the light and proximity sensor.
// Assumes an APB master on clk_sys and converters sending results on a slow serial link.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "lpi_defines.svh"

// What this block does
// - Ambient result below low or above high limit raises ambient condition.
// - Proximity result above threshold raises proximity condition.
// - Combined mode: interrupt pin only when both conditions are present or an unmasked new-result flag is set.
// - Interrupt needs 1, 4, 8 or 16 consecutive qualifying results.
// - Each interrupt shows on the pin and in readable flag bits.
// - Interrupt pin is open-drain, pulled low when active.
// - One ambient conversion started every 100 ms, one sample each.
// - LED sink on for 100 us per proximity cycle, 110 or 220 mA.
// - Programmable sleep between LED pulses, at most 800 ms.
// - Two ambient ranges selectable, 125 or 2000 lux full scale.
// - Address select pin gives one slave address bit; board must tie it.
// - Ambient and proximity run on independent sequencers concurrently.
// - Ambient result is 12 bits, saturating at 4095.
// - Proximity result is 8 bits, full scale 255.
// - Separate enables; both cleared means powered down.
module lpi_sensor_ctrl
	import lpi_pkg::*;
#(
	parameter int         AMB_PERIOD_CYC = `LPI_AMB_PERIOD_CYC,
	parameter int         SLEEP_UNIT_CYC = `LPI_SLEEP_UNIT_CYC,
	parameter int         LED_PULSE_CYC  = `LPI_LED_PULSE_CYC,
	parameter logic [6:0] ADDR_BASE      = 7'h44
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        adcClk,
	input  wire logic        ambData,
	input  wire logic        proxData,
	input  wire logic        ambFrame,
	input  wire logic        proxFrame,
	input  wire logic        slaveAddrSelectPin,
	output logic             ambStart,
	output logic             proxStart,
	output logic             ambientRangeSelect,
	output logic             ledSinkDrive,
	output logic             ledHighAmp,
	output logic             powerDown,
	output logic             intPinOut,
	output logic             intPinOe,
	output logic             irq
);

	logic [6:0]  config_q;
	logic [4:0]  intCfg_q;
	lpi_amb_t    ambLo_q;
	lpi_amb_t    ambHi_q;
	lpi_prox_t   proxThr_q;
	lpi_amb_t    ambResult_q;
	lpi_prox_t   proxResult_q;
	logic [3:0]  irqStat_q;
	logic [3:0]  irqMask_q;
	logic [31:0] prdata_q;
	logic [5:0]  syncA_q;
	logic [5:0]  syncB_q;
	logic        clkPrev_q;
	logic [1:0]  framePrev_q;
	logic [15:0] shift_q [2];
	lpi_cnt_t    ambRun_q;
	lpi_cnt_t    proxRun_q;
	logic [23:0] ambCnt_q;
	logic [23:0] proxCnt_q;
	lpi_prox_e   proxState_q;
	logic        ambStart_q;
	logic        proxStart_q;

	logic        proxEnable;
	logic        ambientEnable;
	logic [2:0]  sleepSel;
	logic [23:0] sleepLen;
	logic        linkRise;
	logic [1:0]  frameS;
	logic [1:0]  newRes;
	lpi_amb_t    ambNew;
	lpi_prox_t   proxNew;
	logic        ambCond;
	logic        proxCond;
	logic        ambFire;
	logic        proxFire;
	logic        wrEn;
	logic        rdHit;
	logic [31:0] rdData;
	logic [3:0]  statPend;
	logic        intActive;

	function automatic logic [15:0] clampTo(input logic [15:0] v, input logic [15:0] lim);
		clampTo = (v > lim) ? lim : v;
	endfunction

	function automatic lpi_cnt_t persistNeed(input logic [1:0] code);
		unique case (code)
			2'h0: persistNeed = 5'h01;
			2'h1: persistNeed = 5'h04;
			2'h2: persistNeed = 5'h08;
			2'h3: persistNeed = 5'h10;
		endcase
	endfunction

	assign proxEnable    = config_q[`LPI_CFG_PROX_EN];
	assign ambientEnable = config_q[`LPI_CFG_AMB_EN];
	assign sleepSel      = config_q[`LPI_CFG_SLEEP_LSB +: 3];
	assign sleepLen      = 24'(SLEEP_UNIT_CYC * (int'(sleepSel) + 1));

	assign ambientRangeSelect = config_q[`LPI_CFG_RANGE];
	assign ledHighAmp = config_q[`LPI_CFG_LED_HIGH];
	assign powerDown  = ~proxEnable & ~ambientEnable;
	assign ambStart   = ambStart_q;
	assign proxStart  = proxStart_q;
	assign ledSinkDrive = (proxState_q == PX_LED);

	// Two-stage synchronisers for all pins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			syncA_q <= 6'h00;
			syncB_q <= 6'h00;
		end else begin
			syncA_q <= {slaveAddrSelectPin, proxFrame, ambFrame, proxData, ambData, adcClk};
			syncB_q <= syncA_q;
		end
	end

	assign frameS   = syncB_q[4:3];
	assign linkRise = syncB_q[0] & ~clkPrev_q;
	assign newRes   = framePrev_q & ~frameS;

	// Serial results, msb first, while frame high
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clkPrev_q   <= 1'b0;
			framePrev_q <= 2'h0;
			shift_q[0]  <= 16'h0000;
			shift_q[1]  <= 16'h0000;
		end else begin
			clkPrev_q   <= syncB_q[0];
			framePrev_q <= frameS;
			for (int i = 0; i < 2; i++) begin
				if (linkRise && frameS[i]) begin
					shift_q[i] <= {shift_q[i][14:0], syncB_q[1 + i]};
				end else if (!frameS[i] && framePrev_q[i]) begin
					shift_q[i] <= 16'h0000;
				end
			end
		end
	end

	assign ambNew  = lpi_amb_t'(clampTo(shift_q[0], `LPI_AMB_MAX));
	assign proxNew = lpi_prox_t'(clampTo(shift_q[1], `LPI_PROX_MAX));
	assign ambCond  = (ambNew < ambLo_q) || (ambNew > ambHi_q);
	assign proxCond = proxNew > proxThr_q;
	assign ambFire  = newRes[0] && ambientEnable && ambCond
		&& (ambRun_q + 5'h01 >= persistNeed(intCfg_q[`LPI_ICF_AMB_P_LSB +: 2]));
	assign proxFire = newRes[1] && proxEnable && proxCond
		&& (proxRun_q + 5'h01 >= persistNeed(intCfg_q[`LPI_ICF_PROX_P_LSB +: 2]));

	// ambient channel result and run count
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ambResult_q <= 12'h000;
			ambRun_q    <= 5'h00;
		end else if (newRes[0] && ambientEnable) begin
			ambResult_q <= ambNew;
			if (!ambCond) begin
				ambRun_q <= 5'h00;
			end else if (ambRun_q != 5'h10) begin
				ambRun_q <= ambRun_q + 5'h01;
			end
		end
	end

	// proximity channel result and run count
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			proxResult_q <= 8'h00;
			proxRun_q    <= 5'h00;
		end else if (newRes[1] && proxEnable) begin
			proxResult_q <= proxNew;
			if (!proxCond) begin
				proxRun_q <= 5'h00;
			end else if (proxRun_q != 5'h10) begin
				proxRun_q <= proxRun_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ambCnt_q   <= 24'h000000;
			ambStart_q <= 1'b0;
		end else if (!ambientEnable) begin
			ambCnt_q   <= 24'h000000;
			ambStart_q <= 1'b0;
		end else begin
			ambStart_q <= (ambCnt_q == 24'h000000);
			if (ambCnt_q == 24'(AMB_PERIOD_CYC - 1)) begin
				ambCnt_q <= 24'h000000;
			end else begin
				ambCnt_q <= ambCnt_q + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			proxState_q <= PX_IDLE;
			proxCnt_q   <= 24'h000000;
			proxStart_q <= 1'b0;
		end else begin
			proxStart_q <= 1'b0;
			proxCnt_q   <= proxCnt_q + 24'h000001;
			if (!proxEnable) begin
				proxState_q <= PX_IDLE;
				proxCnt_q   <= 24'h000000;
			end else begin
				unique case (proxState_q)
					PX_IDLE: begin
						proxState_q <= PX_LED;
						proxCnt_q   <= 24'h000000;
					end
					PX_LED: begin
						if (proxCnt_q == 24'(LED_PULSE_CYC - 1)) begin
							proxState_q <= PX_SLEEP;
							proxCnt_q   <= 24'h000000;
							proxStart_q <= 1'b1;
						end
					end
					PX_SLEEP: begin
						if (proxCnt_q >= sleepLen - 24'h000001) begin
							proxState_q <= PX_LED;
							proxCnt_q   <= 24'h000000;
						end
					end
				endcase
			end
		end
	end

	assign wrEn = psel & penable & pwrite;

	// Control registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			config_q  <= `LPI_RST_CONFIG;
			intCfg_q  <= `LPI_RST_INTCFG;
			ambLo_q   <= `LPI_RST_AMB_LO;
			ambHi_q   <= `LPI_RST_AMB_HI;
			proxThr_q <= `LPI_RST_PROX_THR;
			irqMask_q <= `LPI_RST_IRQ_MASK;
		end else if (wrEn) begin
			unique case (paddr)
				`LPI_OFS_CONFIG:   config_q  <= pwdata[6:0];
				`LPI_OFS_INTCFG:   intCfg_q  <= pwdata[4:0];
				`LPI_OFS_AMB_LO:   ambLo_q   <= pwdata[11:0];
				`LPI_OFS_AMB_HI:   ambHi_q   <= pwdata[11:0];
				`LPI_OFS_PROX_THR: proxThr_q <= pwdata[7:0];
				`LPI_OFS_IRQ_MASK: irqMask_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Write-one-to-clear of the status flags
	assign statPend = (wrEn && paddr == `LPI_OFS_IRQ_STAT) ? (irqStat_q & ~pwdata[3:0]) : irqStat_q;

	// sticky until one written; set wins over clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqStat_q <= 4'h0;
		end else begin
			irqStat_q <= statPend | {newRes[1] & proxEnable, newRes[0] & ambientEnable, proxFire, ambFire};
		end
	end

	assign intActive = (intCfg_q[`LPI_ICF_COMBINE]
		? (irqStat_q[0] & irqStat_q[1] & irqMask_q[0] & irqMask_q[1])
		: |(irqStat_q[1:0] & irqMask_q[1:0])) | (|(irqStat_q[3:2] & irqMask_q[3:2]));
	assign irq       = intActive;
	assign intPinOut = 1'b0;
	assign intPinOe  = intActive;

	// Read decode
	always_comb begin
		rdHit  = 1'b1;
		rdData = 32'h00000000;
		unique case (paddr)
			`LPI_OFS_CONFIG:    rdData[6:0]  = config_q;
			`LPI_OFS_INTCFG:    rdData[4:0]  = intCfg_q;
			`LPI_OFS_AMB_LO:    rdData[11:0] = ambLo_q;
			`LPI_OFS_AMB_HI:    rdData[11:0] = ambHi_q;
			`LPI_OFS_PROX_THR:  rdData[7:0]  = proxThr_q;
			`LPI_OFS_AMB_DATA:  rdData[11:0] = ambResult_q;
			`LPI_OFS_PROX_DATA: rdData[7:0]  = proxResult_q;
			`LPI_OFS_IRQ_STAT:  rdData[3:0]  = irqStat_q;
			`LPI_OFS_IRQ_MASK:  rdData[3:0]  = irqMask_q;
			`LPI_OFS_INFO:      rdData[7:0]  = {powerDown, ADDR_BASE[6:1], syncB_q[5]};
			default:            rdHit        = 1'b0;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata_q <= rdData;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rdHit;

endmodule // lpi_sensor_ctrl

// ### verif/lpi_sc_asserts.sv
// Port checker of the sensor control block.
// Assumes binding to lpi_sensor_ctrl with the same counts.
`timescale 1ns/1ps
module lpi_sc_asserts #(
	parameter int AMB_PERIOD_CYC = 50,
	parameter int LED_PULSE_CYC  = 10
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ambStart,
	input wire logic proxStart,
	input wire logic ledSinkDrive,
	input wire logic powerDown,
	input wire logic intPinOut,
	input wire logic intPinOe,
	input wire logic irq
);
	localparam int AP = AMB_PERIOD_CYC;
	localparam int LP = LED_PULSE_CYC - 1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_pin; intPinOe |-> !intPinOut; endproperty
	a_pin: assert property (p_pin) else $error("pin not pulled low");
	property p_flag; irq == intPinOe; endproperty
	a_flag: assert property (p_flag) else $error("irq and pin disagree");
	property p_hold; irq && !(psel && penable && pwrite) |=> irq; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped alone");
	property p_pd; powerDown |=> !ambStart && !ledSinkDrive; endproperty
	a_pd: assert property (p_pd) else $error("activity in power down");
	property p_led; $rose(ledSinkDrive) |-> ##LP ledSinkDrive ##1 !ledSinkDrive; endproperty
	a_led: assert property (p_led) else $error("led pulse width");
	property p_conv; $fell(ledSinkDrive) && !powerDown |-> ##[0:1] proxStart; endproperty
	a_conv: assert property (p_conv) else $error("no prox start");
	property p_amb; ambStart |-> ##AP (ambStart || powerDown); endproperty
	a_amb: assert property (p_amb) else $error("ambient period");
	c_irq: cover property ($rose(irq));
	c_led: cover property ($rose(ledSinkDrive));
	c_err: cover property (pslverr);
endmodule // lpi_sc_asserts

bind lpi_sensor_ctrl lpi_sc_asserts #(.AMB_PERIOD_CYC(AMB_PERIOD_CYC), .LED_PULSE_CYC(LED_PULSE_CYC)) u_chk (
	.clk_sys, .rst_b, .psel, .penable, .pwrite, .pready, .pslverr, .ambStart, .proxStart,
	.ledSinkDrive, .powerDown, .intPinOut, .intPinOe, .irq);

// ### verif/lpi_conv_model.sv
// Converter link model: framed serial results, msb first.
// Assumes the bench calls send; link clock idles low outside frames.
`timescale 1ns/1ps
module lpi_conv_model (
	output logic adcClk,
	output logic ambData,
	output logic proxData,
	output logic ambFrame,
	output logic proxFrame
);
	initial begin
		adcClk = 1'b0;
		ambData = 1'b0;
		ambFrame = 1'b0;
		proxFrame = 1'b0;
	end
	assign proxData = ambData;
	task automatic send(input logic prox, input logic [15:0] v, input int n);
		#20;
		ambFrame = !prox;
		proxFrame = prox;
		for (int i = n - 1; i >= 0; i--) begin
			ambData = v[i];
			#400 adcClk = 1'b1;
			#400 adcClk = 1'b0;
		end
		#400;
		ambFrame = 1'b0;
		proxFrame = 1'b0;
		// Released line shows the inverse
		ambData = ~ambData;
		#1000;
	endtask
endmodule // lpi_conv_model

// ### verif/lpi_sensor_ctrl_tb.sv
// Bench of the sensor control block: APB calls and converter frames.
// Assumes the design and lpi_defines.svh on the include path.
`timescale 1ns/1ps
`define CHK(n, e, s) begin numChecks++; if ((s) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module lpi_sensor_ctrl_tb;
	logic        clk_sys, rst_b, psel, penable, pwrite, pin, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rdv;
	wire  [31:0] prdata;
	wire         pready, pslverr, ambStart, proxStart, ambientRangeSelect, ledSinkDrive, ledHighAmp;
	wire         powerDown, intPinOut, intPinOe, irq, adcClk, ambData, proxData, ambFrame, proxFrame;
	int          failures, numChecks;

	lpi_sensor_ctrl #(.AMB_PERIOD_CYC(50), .SLEEP_UNIT_CYC(20), .LED_PULSE_CYC(10)) dut (
		.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
		.adcClk, .ambData, .proxData, .ambFrame, .proxFrame, .slaveAddrSelectPin(pin), .ambStart,
		.proxStart, .ambientRangeSelect, .ledSinkDrive, .ledHighAmp, .powerDown, .intPinOut,
		.intPinOe, .irq);
	lpi_conv_model conv (.adcClk, .ambData, .proxData, .ambFrame, .proxFrame);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		// Start every request right after a rising edge
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("reg", e, rdv)
	endtask

	initial begin
		#3000000;
		failures++;
		final_report;
	end

	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pin = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK("pd", 1'b1, powerDown)
		rdc(8'h00, 32'h0);
		rdc(8'h0c, 32'hfff);
		rdc(8'h10, 32'hff);
		rdc(8'h20, 32'h3);
		rdc(8'h24, 32'hc5);
		rdc(8'h40, 32'h0);
		`CHK("slverr", 1'b1, perr)
		apb(1'b1, 8'h00, 32'h0e);
		`CHK("range", 1'b1, ambientRangeSelect)
		`CHK("pd", 1'b0, powerDown)
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h08, 32'h100);
		apb(1'b1, 8'h0c, 32'h800);
		for (int i = 0; i < 7; i++)
			conv.send(1'b0, i == 3 ? 16'h200 : 16'h900, 12);
		rdc(8'h1c, 32'h4);
		conv.send(1'b0, 16'hffff, 16);
		rdc(8'h1c, 32'h5);
		rdc(8'h14, 32'hfff);
		`CHK("irq", 1'b1, irq)
		`CHK("oe", 1'b1, intPinOe)
		`CHK("out", 1'b0, intPinOut)
		repeat (30) @(posedge clk_sys);
		`CHK("hold", 1'b1, irq)
		apb(1'b1, 8'h1c, 32'hf);
		`CHK("clr", 1'b0, irq)
		apb(1'b1, 8'h10, 32'h80);
		apb(1'b1, 8'h04, 32'h10);
		apb(1'b1, 8'h00, 32'h0b);
		`CHK("range", 1'b0, ambientRangeSelect)
		wait (ledSinkDrive === 1'b1);
		`CHK("amp", 1'b1, ledHighAmp)
		conv.send(1'b1, 16'h80, 8);
		rdc(8'h1c, 32'h8);
		conv.send(1'b1, 16'h81, 8);
		rdc(8'h1c, 32'ha);
		rdc(8'h18, 32'h81);
		`CHK("both", 1'b0, irq)
		conv.send(1'b0, 16'h050, 12);
		rdc(8'h1c, 32'hf);
		`CHK("both", 1'b1, irq)
		// Power down in the sleep gap, not inside an LED pulse
		@(negedge ledSinkDrive);
		apb(1'b1, 8'h00, 32'h0);
		`CHK("pd", 1'b1, powerDown)
		pin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rdc(8'h24, 32'hc4);
		final_report;
	end
endmodule // lpi_sensor_ctrl_tb
